/* core/efc_map.svh */
// Contract
// R01: top three bits must read 100
// R02: invalid data: volume on serial0, dsp off
// R03: four-byte byte0 enable bit decode
// R04: modem device or serial port 1
// R05: extra device or dsp serial port
// R06: merged device uses extra ranges, irqs
// R07: volume routing bits never both set
// R08: irq12_13 select gated by second irq; code passes byte1 bit0 through ungated
// R09: irq3_9 select gated by modem/second irq; code passes byte1 bit1 through ungated
// R10: reset output select on control pin0
// R11: range0 size code to length
// R12: second range enable else size zero
// R13: range1 size uses same mapping
// R14: no eeprom clears listed flags
// R15: no eeprom sets selects, volume from pin
// R16: legacy single-byte bit decode
// R17: legacy size or volume location select
// R18: legacy extra irq, rising edge type
// R19: legacy no eeprom defaults, volume from pin
// R20: legacy to four-byte translation
// R21: default pin functions when absent/invalid
// R22: reload after reset and config reset
// R23: drivers off while loading or invalid
// R24: decoded flags update atomically
`ifndef EFC_MAP_SVH
`define EFC_MAP_SVH
`define EFC_VALID_PAT 3'h4
`define EFC_B0_MODEM 0
`define EFC_B0_EXTRA 1
`define EFC_B0_MERGED 2
`define EFC_B0_VOL_S0 3
`define EFC_B0_VOL_DSP 4
`define EFC_B1_IRQ12_13 0
`define EFC_B1_IRQ3_9 1
`define EFC_B1_RST_OUT 2
`define EFC_B2_IRQ4_10 4
`define EFC_B2_IRQ11_15 5
`define EFC_B2_IRQ9_14 6
`define EFC_B2_IRQ4_9_11 7
`define EFC_B3_XINV 0
`define EFC_B3_MINV 1
`define EFC_B3_IRQ2 2
`define EFC_B3_RANGE2 3
`define EFC_L_XIRQ 2
`define EFC_L_VOL 3
`define EFC_L_SEL 4
`define EFC_RST_CFG_BIT 0
`define EFC_STARTUP_NS 1000
`define EFC_STARTUP_CYC ((`EFC_STARTUP_NS + 19) / 20)
`endif

/* core/efc_pkg.sv */
package efc_pkg;
    typedef enum logic [2:0]
    {
        EFC_IDLE = 3'b000,
        EFC_WAIT = 3'b001,
        EFC_PROBE = 3'b010,
        EFC_READ = 3'b011,
        EFC_APPLY = 3'b100
    } efc_state_t;
    typedef logic [4:0] efc_len_t;
endpackage

/* core/efc_size_dec.sv */
`include "efc_map.svh"
module efc_size_dec
    import efc_pkg::*;
(
    input wire logic [3:0] i_code,
    input wire logic i_enable,
    output efc_len_t o_len
);
    // code to byte length, unlisted codes read as zero
    always_comb
    begin
        o_len = 5'h00;
        if (i_enable)
        begin
            case (i_code)
                4'h0: o_len = 5'h10; // see R11
                4'h8: o_len = 5'h08;
                4'hc: o_len = 5'h04;
                4'he: o_len = 5'h02;
                4'hf: o_len = 5'h01;
                default: o_len = 5'h00;
            endcase
        end
    end
endmodule

/* core/efc_flag_decoder.sv */
`include "efc_map.svh"
module efc_flag_decoder
    import efc_pkg::*;
#(
    parameter int STARTUP_CYC = `EFC_STARTUP_CYC
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_legacy_format,
    input wire logic i_eeprom_clock_pin,
    input wire logic i_eeprom_data_pin,
    input wire logic i_cfg_reset_wr,
    input wire logic [7:0] i_cfg_reset_data,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte_data,
    output logic o_read_req,
    output logic o_loading,
    output logic o_eeprom_used,
    output logic o_modem_device_enable,
    output logic o_extra_device_enable,
    output logic o_merged_device_enable,
    output logic o_volume_on_serial0,
    output logic o_volume_on_dsp_port,
    output logic o_serial1_enable,
    output logic o_dsp_serial_port_enable,
    output logic o_irq12_13_select,
    output logic o_irq3_9_select,
    output logic o_irq4_10_select,
    output logic o_irq11_15_select,
    output logic o_irq9_14_select,
    output logic o_irq4_9_11_select,
    output logic o_extra_irq_invert,
    output logic o_modem_irq_invert,
    output logic o_second_irq_enable,
    output logic o_second_range_enable,
    output logic o_reset_out_select,
    output logic o_extra_irq_present,
    output logic o_extra_irq_rising,
    output logic [4:0] o_range0_len,
    output logic [4:0] o_range1_len,
    output logic o_dir_pin_drive_enable
);
    efc_state_t state_reg;
    logic clk_s1_reg, clk_s2_reg, dat_s1_reg, dat_s2_reg;
    logic [15:0] wait_reg;
    logic [1:0] idx_reg;
    logic [7:0] b0_reg, b1_reg, b2_reg;
    logic valid_reg;
    logic [3:0] sz0_next, sz1_next;
    logic range2_next;
    efc_len_t len0, len1;
    logic last_byte;
    logic absent_reg;
    logic load_ok_reg;

    // pin synchronisers
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            dat_s1_reg <= 1'b0;
            dat_s2_reg <= 1'b0;
        end
        else
        begin
            clk_s1_reg <= i_eeprom_clock_pin;
            clk_s2_reg <= clk_s1_reg;
            dat_s1_reg <= i_eeprom_data_pin;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    assign last_byte = i_legacy_format ? 1'b1 : (idx_reg == 2'd3);

    // load sequencing
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= EFC_WAIT;
            wait_reg <= 16'h0000;
            idx_reg <= 2'd0;
        end
        else if (i_cfg_reset_wr && i_cfg_reset_data[`EFC_RST_CFG_BIT])
        begin
            state_reg <= EFC_WAIT; // see R22
            wait_reg <= 16'h0000;
            idx_reg <= 2'd0;
        end
        else
        begin
            case (state_reg)
                EFC_IDLE: state_reg <= EFC_IDLE;
                EFC_WAIT:
                begin
                    wait_reg <= wait_reg + 16'h0001;
                    if (wait_reg >= 16'(STARTUP_CYC - 1))
                    begin
                        state_reg <= EFC_PROBE; // see R22
                    end
                end
                EFC_PROBE:
                begin
                    idx_reg <= 2'd0;
                    state_reg <= clk_s2_reg ? EFC_READ : EFC_APPLY;
                end
                EFC_READ:
                begin
                    if (i_byte_valid)
                    begin
                        if (idx_reg == 2'd0 && i_byte_data[7:5] != `EFC_VALID_PAT)
                        begin
                            state_reg <= EFC_APPLY; // see R01
                        end
                        else if (last_byte)
                        begin
                            state_reg <= EFC_APPLY;
                        end
                        else
                        begin
                            idx_reg <= idx_reg + 2'd1;
                        end
                    end
                end
                EFC_APPLY: state_reg <= EFC_IDLE;
                default: state_reg <= EFC_IDLE;
            endcase
        end
    end

    // byte capture
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            b0_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            valid_reg <= 1'b0;
        end
        else if (state_reg == EFC_PROBE)
        begin
            valid_reg <= 1'b0;
        end
        else if (state_reg == EFC_READ && i_byte_valid)
        begin
            case (idx_reg)
                2'd0: b0_reg <= i_byte_data;
                2'd1: b1_reg <= i_byte_data;
                2'd2: b2_reg <= i_byte_data;
                default: b2_reg <= b2_reg;
            endcase
            if (idx_reg == 2'd0)
            begin
                valid_reg <= (i_byte_data[7:5] == `EFC_VALID_PAT); // see R01
            end
        end
    end

    // size codes as they will stand after apply
    always_comb
    begin
        sz0_next = 4'h0;
        sz1_next = 4'h0;
        range2_next = 1'b0;
        if (i_legacy_format)
        begin
            sz0_next = {~b0_reg[`EFC_L_SEL], 3'b000}; // see R17
        end
        else
        begin
            sz0_next = b2_reg[3:0]; // see R11
            sz1_next = i_byte_data[7:4]; // see R13
            range2_next = i_byte_data[`EFC_B3_RANGE2]; // see R12
        end
    end

    logic [3:0] sz0_reg, sz1_reg;
    assign o_range0_len = len0;
    assign o_range1_len = len1;

    efc_size_dec u_dec0
    (
        .i_code(sz0_reg),
        .i_enable(o_extra_device_enable),
        .o_len(len0)
    );

    efc_size_dec u_dec1
    (
        .i_code(sz1_reg),
        .i_enable(o_extra_device_enable && o_second_range_enable), // see R12
        .o_len(len1)
    );

    // decoded flags, updated together on the final byte or at apply
    logic fin_ok;
    assign fin_ok = state_reg == EFC_READ && i_byte_valid && last_byte && valid_reg
        && idx_reg != 2'd0 || (state_reg == EFC_READ && i_byte_valid && i_legacy_format
        && i_byte_data[7:5] == `EFC_VALID_PAT);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_eeprom_used <= 1'b0;
            o_modem_device_enable <= 1'b0;
            o_extra_device_enable <= 1'b0;
            o_merged_device_enable <= 1'b0;
            o_volume_on_serial0 <= 1'b1;
            o_volume_on_dsp_port <= 1'b0;
            o_irq12_13_select <= 1'b0;
            o_irq3_9_select <= 1'b0;
            o_irq4_10_select <= 1'b1;
            o_irq11_15_select <= 1'b1;
            o_irq9_14_select <= 1'b0;
            o_irq4_9_11_select <= 1'b1;
            o_extra_irq_invert <= 1'b0;
            o_modem_irq_invert <= 1'b0;
            o_second_irq_enable <= 1'b0;
            o_second_range_enable <= 1'b0;
            o_reset_out_select <= 1'b0;
            o_extra_irq_present <= 1'b0;
            sz0_reg <= 4'h0;
            sz1_reg <= 4'h0;
        end
        else if (fin_ok) // see R24
        begin
            o_eeprom_used <= 1'b1;
            sz0_reg <= sz0_next;
            sz1_reg <= sz1_next;
            o_second_range_enable <= range2_next;
            if (i_legacy_format)
            begin
                // see R16
                o_modem_device_enable <= i_byte_data[`EFC_B0_MODEM];
                o_extra_device_enable <= i_byte_data[`EFC_B0_EXTRA];
                o_merged_device_enable <= 1'b0;
                o_volume_on_serial0 <= i_byte_data[`EFC_L_VOL] & ~i_byte_data[`EFC_L_SEL]
                    & ~i_byte_data[`EFC_B0_EXTRA]; // see R17
                o_volume_on_dsp_port <= i_byte_data[`EFC_L_VOL] & i_byte_data[`EFC_L_SEL]
                    & ~i_byte_data[`EFC_B0_EXTRA];
                o_extra_irq_present <= i_byte_data[`EFC_L_XIRQ]; // see R18
                o_irq12_13_select <= 1'b0;
                o_irq3_9_select <= 1'b0;
                o_reset_out_select <= 1'b0;
                o_irq4_10_select <= ~i_byte_data[`EFC_B0_MODEM];
                o_irq11_15_select <= 1'b1;
                o_irq9_14_select <= 1'b0;
                o_irq4_9_11_select <= 1'b0;
                o_extra_irq_invert <= 1'b0;
                o_modem_irq_invert <= 1'b0;
                o_second_irq_enable <= 1'b0;
                o_second_range_enable <= 1'b0;
                sz0_reg <= {~i_byte_data[`EFC_L_SEL], 3'b000};
            end
            else
            begin
                // see R03
                o_modem_device_enable <= b0_reg[`EFC_B0_MODEM];
                o_extra_device_enable <= b0_reg[`EFC_B0_EXTRA];
                o_merged_device_enable <= b0_reg[`EFC_B0_MERGED]; // see R06
                o_volume_on_serial0 <= b0_reg[`EFC_B0_VOL_S0]; // see R07
                o_volume_on_dsp_port <= b0_reg[`EFC_B0_VOL_DSP] & ~b0_reg[`EFC_B0_VOL_S0];
                o_irq12_13_select <= b1_reg[`EFC_B1_IRQ12_13]; // see R08
                o_irq3_9_select <= b1_reg[`EFC_B1_IRQ3_9]; // see R09
                o_reset_out_select <= b1_reg[`EFC_B1_RST_OUT]; // see R10
                o_irq4_10_select <= b2_reg[`EFC_B2_IRQ4_10];
                o_irq11_15_select <= b2_reg[`EFC_B2_IRQ11_15];
                o_irq9_14_select <= b2_reg[`EFC_B2_IRQ9_14];
                o_irq4_9_11_select <= b2_reg[`EFC_B2_IRQ4_9_11];
                o_extra_irq_invert <= i_byte_data[`EFC_B3_XINV];
                o_modem_irq_invert <= i_byte_data[`EFC_B3_MINV];
                o_second_irq_enable <= i_byte_data[`EFC_B3_IRQ2];
                o_extra_irq_present <= 1'b1;
            end
        end
        else if (state_reg == EFC_APPLY && !load_ok_reg)
        begin
            // absent or invalid eeprom defaults, see R14, R15, R19, R21
            o_eeprom_used <= 1'b0;
            o_modem_device_enable <= 1'b0;
            o_extra_device_enable <= 1'b0;
            o_merged_device_enable <= 1'b0;
            o_volume_on_dsp_port <= 1'b0;
            o_reset_out_select <= 1'b0;
            o_second_irq_enable <= 1'b0;
            o_irq9_14_select <= 1'b0;
            o_extra_irq_invert <= 1'b0;
            o_modem_irq_invert <= 1'b0;
            o_irq12_13_select <= 1'b0;
            o_irq3_9_select <= 1'b0;
            o_irq4_10_select <= 1'b1;
            o_irq11_15_select <= 1'b1;
            o_irq4_9_11_select <= 1'b1;
            o_extra_irq_present <= 1'b0;
            o_second_range_enable <= 1'b0;
            sz0_reg <= 4'h0;
            sz1_reg <= 4'h0;
            // see R02: invalid data forces volume on serial0
            o_volume_on_serial0 <= absent_reg ? dat_s2_reg : 1'b1;
        end
    end

    // track which path ended the load
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            absent_reg <= 1'b0;
            load_ok_reg <= 1'b0;
        end
        else if (state_reg == EFC_PROBE)
        begin
            absent_reg <= ~clk_s2_reg;
            load_ok_reg <= 1'b0;
        end
        else if (fin_ok)
        begin
            load_ok_reg <= 1'b1;
        end
    end

    // derived enables and pin drive
    assign o_serial1_enable = ~o_modem_device_enable & ~o_merged_device_enable
        & ~o_second_irq_enable; // see R04
    assign o_dsp_serial_port_enable = load_ok_reg & ~o_extra_device_enable
        & ~o_volume_on_dsp_port; // see R05, R02
    assign o_extra_irq_rising = o_extra_irq_present & i_legacy_format; // see R18
    assign o_loading = state_reg != EFC_IDLE;
    assign o_read_req = state_reg == EFC_READ;
    assign o_dir_pin_drive_enable = ~o_loading & load_ok_reg; // see R23
endmodule

/* dv/efc_flag_properties.sv */
module efc_flag_props
#(
    parameter int STARTUP_CYC = 2
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_cfg_reset_wr,
    input wire logic [7:0] i_cfg_reset_data,
    input wire logic o_read_req,
    input wire logic o_loading,
    input wire logic o_modem_device_enable,
    input wire logic o_extra_device_enable,
    input wire logic o_merged_device_enable,
    input wire logic o_volume_on_serial0,
    input wire logic o_volume_on_dsp_port,
    input wire logic o_serial1_enable,
    input wire logic o_dsp_serial_port_enable,
    input wire logic o_second_irq_enable,
    input wire logic o_second_range_enable,
    input wire logic [4:0] o_range0_len,
    input wire logic [4:0] o_range1_len,
    input wire logic o_dir_pin_drive_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_drive_off_load: assert property (o_loading |-> !o_dir_pin_drive_enable)
        else $error("pin drivers enabled during load");
    a_flags_held: assert property (o_read_req ##1 o_read_req |->
        $stable({o_modem_device_enable, o_extra_device_enable, o_range0_len}))
        else $error("flags changed before last byte");
    a_cfg_restart: assert property (
        !o_loading && i_cfg_reset_wr && i_cfg_reset_data[0] |=> o_loading)
        else $error("config reset did not start a load");
    a_cfg_ignore: assert property (
        !o_loading && i_cfg_reset_wr && !i_cfg_reset_data[0] |=> !o_loading)
        else $error("load started without bit 0");
    a_load_bounded: assert property ($rose(o_loading) |-> ##[1:200] !o_loading)
        else $error("load did not finish");
    a_range_legal: assert property (
        o_range0_len inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        else $error("illegal range length");
    a_range1_off: assert property (!o_second_range_enable |-> o_range1_len == 5'h00)
        else $error("second range sized while disabled");
    a_vol_excl: assert property (!(o_volume_on_serial0 && o_volume_on_dsp_port))
        else $error("volume on both ports");
    a_extra_no_dsp: assert property (o_extra_device_enable |-> !o_dsp_serial_port_enable)
        else $error("dsp port on with extra device");
    a_serial1_gate: assert property (
        o_modem_device_enable || o_merged_device_enable || o_second_irq_enable
        |-> !o_serial1_enable)
        else $error("serial port 1 on while claimed");
endmodule

bind efc_flag_decoder efc_flag_props #(.STARTUP_CYC(STARTUP_CYC)) u_props (.*);

/* dv/efc_eeprom_model.sv */
module efc_eeprom_model
(
    input wire logic i_mclk,
    input wire logic i_read_req,
    input wire logic [31:0] i_image,
    input wire logic i_slow,
    output logic o_byte_valid,
    output logic [7:0] o_byte_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx = 0;
    int gap = 0;

    initial
    begin
        o_byte_valid = 1'b0;
        o_byte_data = 8'h00;
    end

    // serves flag bytes in order while the request is held, up to four per request
    always @(posedge i_mclk)
    begin
        logic v;
        logic [7:0] d;
        #1;
        v = 1'b0;
        // released line alternates between the complement of the last byte and the last byte
        d = ~o_byte_data;
        if (o_byte_valid)
            idx++;
        if (!i_read_req)
        begin
            idx = 0;
            gap = 0;
        end
        else if (gap > 0)
            gap--;
        else if (idx < 4)
        begin
            v = 1'b1;
            d = i_image[8*idx +: 8];
            gap = i_slow ? 3 : 0;
        end
        o_byte_valid = v;
        o_byte_data = d;
    end
endmodule

/* dv/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_legacy_format = 1'b0, i_eeprom_clock_pin = 1'b1;
    logic i_eeprom_data_pin = 1'b0, i_cfg_reset_wr = 1'b0, i_byte_valid, slow = 1'b0;
    logic [7:0] i_cfg_reset_data = 8'h00, i_byte_data;
    logic o_read_req, o_loading, o_eeprom_used, o_modem_device_enable, o_extra_device_enable;
    logic o_merged_device_enable, o_volume_on_serial0, o_volume_on_dsp_port, o_serial1_enable;
    logic o_dsp_serial_port_enable, o_irq12_13_select, o_irq3_9_select, o_irq4_10_select;
    logic o_irq11_15_select, o_irq9_14_select, o_irq4_9_11_select, o_extra_irq_invert;
    logic o_modem_irq_invert, o_second_irq_enable, o_second_range_enable, o_reset_out_select;
    logic o_extra_irq_present, o_extra_irq_rising, o_dir_pin_drive_enable;
    logic [4:0] o_range0_len, o_range1_len;
    logic [31:0] w = 32'h0000_0000;
    logic [3:0] codes [5] = '{4'h0, 4'h8, 4'hc, 4'he, 4'hf};
    int fail_count = 0;
    int checked = 0;

    always #10 i_mclk = ~i_mclk;

    efc_flag_decoder #(.STARTUP_CYC(2)) uut (.*);
    efc_eeprom_model u_eep (.i_mclk(i_mclk), .i_read_req(o_read_req), .i_image(w),
        .i_slow(slow), .o_byte_valid(i_byte_valid), .o_byte_data(i_byte_data));

    task automatic chk(string n, logic [4:0] e, logic [4:0] g);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    function automatic logic [4:0] len(logic [3:0] c);
        case (c)
            4'h0: return 5'h10;
            4'h8: return 5'h08;
            4'hc: return 5'h04;
            4'he: return 5'h02;
            4'hf: return 5'h01;
            default: return 5'h00;
        endcase
    endfunction

    // legacy flag byte translated into the four-byte image
    function automatic logic [31:0] xlat(logic [4:0] f);
        return {8'h00, 2'b00, 1'b1, ~f[0], ~f[4], 3'b000, 8'h00,
            3'b100, f[3] & f[4], f[3] & ~f[4], 1'b0, f[1:0]};
    endfunction

    task automatic complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic idle();
        for (int k = 0; k < 300 && o_loading; k++)
        begin
            @(posedge i_mclk);
            #1;
        end
        chk("idle", 5'h00, o_loading);
    endtask

    // set pins and image, then request a reload
    task automatic load(logic lg, logic ck, logic [31:0] im);
        i_legacy_format = lg;
        i_eeprom_clock_pin = ck;
        i_eeprom_data_pin = 1'($urandom);
        w = im;
        slow = 1'($urandom);
        repeat (3) @(posedge i_mclk);
        #1 i_cfg_reset_wr = 1'b1;
        i_cfg_reset_data = 8'($urandom) | 8'h01;
        @(posedge i_mclk);
        #1 i_cfg_reset_wr = 1'b0;
        chk("start", 5'h01, o_loading);
        idle();
    endtask

    initial
    begin
        #(20 * 20000);
        fail_count++;
        complete_run();
    end

    initial
    begin
        logic [31:0] r;
        logic m, x, g, vs, vd;
        void'($urandom(32'h00d6));
        repeat (20) @(posedge i_mclk);
        #1;
        chk("rst", 5'h01, {o_modem_device_enable, o_extra_device_enable,
            o_volume_on_serial0});
        i_rst_n = 1'b1;
        @(posedge i_mclk);
        #1;
        chk("boot", 5'h01, o_loading);
        idle();
        i_cfg_reset_data = 8'hfe;
        i_cfg_reset_wr = 1'b1;
        @(posedge i_mclk);
        #1 i_cfg_reset_wr = 1'b0;
        @(posedge i_mclk);
        #1;
        chk("no_reload", 5'h00, o_loading);
        for (int i = 0; i < 60; i++)
        begin
            r = $urandom;
            m = r[0] && !r[2] && i != 0;
            x = r[1] || r[2] || i == 0;
            g = r[2] || i == 0;
            vs = r[3];
            vd = r[4] && !vs;
            if (i % 5 == 0)
            begin
                // byte3 size from legal table, second irq forced when merged
                load(1'b0, 1'b1, {codes[$urandom % 5], r[5], r[6] | g, r[8:7],
                    r[15:12], codes[$urandom % 5], r[23:16], 3'b100, vd, vs, g, x, m});
                chk("byte0", {vd, vs, g, x, m}, {o_volume_on_dsp_port, o_volume_on_serial0,
                    o_merged_device_enable, o_extra_device_enable, o_modem_device_enable});
                chk("byte3", {1'b1, w[27:24]}, {o_eeprom_used, o_second_range_enable,
                    o_second_irq_enable, o_modem_irq_invert, o_extra_irq_invert});
                chk("serial1", !m && !g && !w[26], o_serial1_enable);
                chk("dsp", !x && !vd, o_dsp_serial_port_enable);
                chk("rst_out", w[10], o_reset_out_select);
                chk("byte2", {1'b0, w[23:20]}, {1'b0, o_irq4_9_11_select,
                    o_irq9_14_select, o_irq11_15_select, o_irq4_10_select});
                chk("drive_on", 5'h01, o_dir_pin_drive_enable);
                if (w[26] && !m)
                    chk("irq12_13", w[8], o_irq12_13_select);
                if (w[26] || m)
                    chk("irq3_9", w[9], o_irq3_9_select);
                if (x)
                    chk("range0", len(w[19:16]), o_range0_len);
                if (x)
                    chk("range1", w[27] ? len(w[31:28]) : 5'h00, o_range1_len);
            end
            else if (i % 5 == 1)
            begin
                load(r[8], 1'b1, {r[31:8], r[7:5] == 3'b100 ? 3'b000 : r[7:5], r[4:0]});
                chk("invalid", 5'h04, {o_modem_device_enable, o_extra_device_enable,
                    o_volume_on_serial0, o_dsp_serial_port_enable, o_eeprom_used});
                chk("drive_off", 5'h00, o_dir_pin_drive_enable);
            end
            else if (i % 5 == 2)
            begin
                load(1'b0, 1'b0, r);
                chk("clr_a", 5'h00, {o_modem_device_enable, o_extra_device_enable,
                    o_merged_device_enable, o_volume_on_dsp_port, o_reset_out_select});
                chk("clr_b", 5'h00, {o_second_irq_enable, o_irq9_14_select,
                    o_extra_irq_invert, o_modem_irq_invert, o_eeprom_used});
                chk("set_c", 5'h07, {2'b00, o_irq4_10_select, o_irq11_15_select,
                    o_irq4_9_11_select});
                chk("vol_pin", i_eeprom_data_pin, o_volume_on_serial0);
            end
            else if (i % 5 == 3)
            begin
                load(1'b1, 1'b1, {r[31:8], 3'b100, r[4:0]});
                chk("legacy", {3'b000, r[1:0]}, {o_extra_device_enable,
                    o_modem_device_enable});
                if (r[1])
                    chk("lg_len", r[4] ? 5'h10 : 5'h08, o_range0_len);
                if (r[1])
                    chk("lg_irq", {r[2], r[2]}, {o_extra_irq_present,
                        o_extra_irq_rising});
                else
                    chk("lg_vol", {r[3] & r[4], r[3] & !r[4]}, {o_volume_on_dsp_port,
                        o_volume_on_serial0});
                load(1'b0, 1'b1, xlat(r[4:0]));
                chk("xlat", {1'b0, ~r[0], 1'b1, r[1:0]}, {o_merged_device_enable,
                    o_irq4_10_select, o_irq11_15_select, o_extra_device_enable,
                    o_modem_device_enable});
                chk("xlat_vol", {r[3] & r[4], r[3] & !r[4]}, {o_volume_on_dsp_port,
                    o_volume_on_serial0});
                if (r[1])
                    chk("xlat_len", r[4] ? 5'h10 : 5'h08, o_range0_len);
            end
            else
            begin
                load(1'b1, 1'b0, r);
                chk("lg_abs", 5'h00, {o_modem_device_enable, o_extra_device_enable,
                    o_extra_irq_present, o_volume_on_dsp_port});
                chk("lg_pin", i_eeprom_data_pin, o_volume_on_serial0);
            end
        end
        complete_run();
    end
endmodule
